// file: core/frsc_pkg.sv
// Purpose: shared constants and types of the fast role swap control block
// Assumes: 20 MHz aclk, AXI4-Lite with 32-bit data
// Notes: register byte address is four times the register index

package frsc_pkg;

    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // register indices and byte addresses
    localparam logic [15:0] IDX_CTL = 16'h08A0;
    localparam logic [15:0] IDX_DEB = 16'h08A2;
    localparam logic [15:0] IDX_TXLEN = 16'h08A4;
    localparam logic [15:0] IDX_PINSEL = 16'h08A7;
    localparam logic [15:0] IDX_INT_STS = 16'h08B0;
    localparam logic [15:0] IDX_INT_MASK = 16'h08B1;
    localparam logic [15:0] ADDR_CTL = {IDX_CTL[13:0], 2'h0};
    localparam logic [15:0] ADDR_DEB = {IDX_DEB[13:0], 2'h0};
    localparam logic [15:0] ADDR_TXLEN = {IDX_TXLEN[13:0], 2'h0};
    localparam logic [15:0] ADDR_PINSEL = {IDX_PINSEL[13:0], 2'h0};
    localparam logic [15:0] ADDR_INT_STS = {IDX_INT_STS[13:0], 2'h0};
    localparam logic [15:0] ADDR_INT_MASK = {IDX_INT_MASK[13:0], 2'h0};

    // control and pin select register fields
    localparam int CTL_REQ = 15;
    localparam int CTL_DET = 14;
    localparam int CTL_PIN_EN = 13;
    localparam int CTL_PIN_LVL = 12;
    localparam int CTL_DAC_HI = 11;
    localparam int CTL_DAC_LO = 9;
    localparam int CTL_OVR = 8;
    localparam int CTL_SEL_HI = 5;
    localparam int CTL_SEL_LO = 4;
    localparam int PINSEL_HI = 7;
    localparam int PINSEL_LO = 4;

    // interrupt status bits
    localparam int INT_W = 2;
    localparam int INT_TX_DONE = 0;
    localparam int INT_DETECT = 1;

    // reset values
    localparam logic PIN_LVL_RST = 1'h1;
    localparam logic [2:0] DAC_RST = 3'h0;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] PINSEL_RST = 4'h0;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_MHZ = 20;
    localparam int DAC_MHZ = 12;
    localparam int US_NS = 1000;
    localparam int DEB_UNIT_NS = 5000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int CYC_PER_DEB = DEB_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [2:0] DAC_MAX_CODE = 3'h6;

    // pins
    localparam int GP_N = 16;
    localparam int GP_SEL_W = 4;
    localparam int SYNC_N = GP_N + 2;
    localparam logic [SYNC_N-1:0] SYNC_RST = {2'h3, 16'h0000};

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // transmit sequencer
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SETUP = 3'b010,
        TX_DRIVE = 3'b100
    } frsc_tx_e;

endpackage : frsc_pkg

// file: core/frsc_tick_if.sv
// Purpose: rate enables between the timebase and the control core
// Assumes: all signals on aclk
// Notes: us_restart realigns the microsecond enable

`timescale 1ns/1ns

interface frsc_tick_if;
    logic tick_dac;
    logic tick_us;
    logic tick_deb;
    logic us_restart;
    modport src (output tick_dac, output tick_us, output tick_deb, input us_restart);
    modport snk (input tick_dac, input tick_us, input tick_deb, output us_restart);
endinterface : frsc_tick_if

// file: core/frsc_timebase.sv
// Purpose: one-cycle enables for the 12 MHz, 1 us and debounce rates
// Assumes: 20 MHz aclk
// Notes: 12 MHz enable is a fractional accumulator, so its spacing jitters

`timescale 1ns/1ns

module frsc_timebase
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // enables
    frsc_tick_if.src tick
);
    import frsc_pkg::*;

    logic [4:0] acc_r;
    logic [4:0] us_cnt_r;
    logic [6:0] deb_cnt_r;
    logic dac_r;
    logic us_r;
    logic deb_r;
    logic [4:0] acc_sum;
    logic dac_wrap;
    logic us_wrap;
    logic deb_wrap;

    // 12 of every 20 cycles carry the dac enable
    assign acc_sum = acc_r + 5'(DAC_MHZ);
    assign dac_wrap = acc_sum >= 5'(CLK_MHZ);
    assign us_wrap = us_cnt_r == 5'(CYC_PER_US - 1);
    assign deb_wrap = deb_cnt_r == 7'(CYC_PER_DEB - 1);

    // dac rate accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 5'h00;
            dac_r <= 1'b0;
        end else begin
            acc_r <= dac_wrap ? acc_sum - 5'(CLK_MHZ) : acc_sum;
            dac_r <= dac_wrap;
        end
    end

    // microsecond counter, restartable so a drive lasts whole microseconds
    always_ff @(posedge aclk) begin
        if (!aresetn || tick.us_restart) begin
            us_cnt_r <= 5'h00;
            us_r <= 1'b0;
        end else begin
            us_cnt_r <= us_wrap ? 5'h00 : us_cnt_r + 5'h01;
            us_r <= us_wrap;
        end
    end

    // debounce sample counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deb_cnt_r <= 7'h00;
            deb_r <= 1'b0;
        end else begin
            deb_cnt_r <= deb_wrap ? 7'h00 : deb_cnt_r + 7'h01;
            deb_r <= deb_wrap;
        end
    end

    assign tick.tick_dac = dac_r;
    assign tick.tick_us = us_r;
    assign tick.tick_deb = deb_r;

endmodule : frsc_timebase

// file: core/frsc_core.sv
// Purpose: fast role swap signalling, detection and PD MAC isolation
// Assumes: 20 MHz aclk, AXI4-Lite slave, CC and pin inputs asynchronous
// Notes: CC pins are open drain, driven low only
//
// Overview of operation
// - writing one to swap_request sends swap signalling for the programmed length.
// - with swap_detect_enable set the selected CC line is watched, otherwise nothing is.
// - with pin_trigger_enable set, the selected pin asserting starts a transmission.
// - pin_trigger_level gives the asserting pin level and resets to one.
// - dac_setup_delay codes 0..6 give 0..500 ns of setup and code 7 gives 500 ns.
// - each setup code step is one period of the 12 MHz rate.
// - while mac_override is set the PD MAC is cut off from the CC pin in use.
// - the transmit sequencer sets mac_override as it starts driving.
// - a debounced received swap signal sets mac_override.
// - mac_override holds until firmware writes zero, which reconnects the MAC.
// - cc_pin_select 00 picks CC1, 01 picks CC2, 1x picks both.
// - a request is signalled by holding the CC line low for the whole interval.
// - swap_transmit_length counts in microseconds.
// - swap_cc_debounce sets how long received signalling must persist.
//
// Implementation choice: the AXI4-Lite interface to the registers.

`timescale 1ns/1ns

module frsc_core
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address
    input wire logic [frsc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [frsc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read
    input wire logic [frsc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [frsc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cc pins, open drain
    input wire logic cc1_in,
    output logic cc1_out,
    output logic cc1_oe_n,
    input wire logic cc2_in,
    output logic cc2_out,
    output logic cc2_oe_n,
    // trigger pins
    input wire logic [frsc_pkg::GP_N-1:0] general_purpose_pin,
    // pd mac isolation and interrupt
    output logic mac_cc1_disconnect,
    output logic mac_cc2_disconnect,
    output logic irq
);
    import frsc_pkg::*;

    frsc_tick_if tick ();

    frsc_timebase u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick.src)
    );

    // bus state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic [15:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // register state
    logic swap_request_r;
    logic swap_detect_enable_r;
    logic pin_trigger_enable_r;
    logic pin_trigger_level_r;
    logic [2:0] dac_setup_delay_r;
    logic mac_override_r;
    logic [1:0] cc_pin_select_r;
    logic [7:0] swap_cc_debounce_r;
    logic [7:0] swap_transmit_length_r;
    logic [3:0] trigger_pin_select_r;
    logic [INT_W-1:0] int_sts_r;
    logic [INT_W-1:0] int_mask_r;

    // pin state
    logic [SYNC_N-1:0] sync1_r;
    logic [SYNC_N-1:0] sync2_r;
    logic [SYNC_N-1:0] sync3_r;
    logic [SYNC_N-1:0] pin_r;
    logic pin_match_d_r;

    // sequencer and detector state
    frsc_tx_e tx_state_r;
    frsc_tx_e tx_state_nxt;
    logic [2:0] dac_cnt_r;
    logic [7:0] us_cnt_r;
    logic [7:0] det_cnt_r;
    logic det_seen_r;
    logic cc_low_r;
    logic mac1_r;
    logic mac2_r;
    logic irq_r;

    // decode wires
    logic wr_fire;
    logic wr_ctl;
    logic wr_hit;
    logic lane0;
    logic lane1;
    logic [15:0] ctl_word;
    logic [31:0] rd_word;
    logic rd_hit;
    logic sel_cc1;
    logic sel_cc2;
    logic pin_match;
    logic pin_fire;
    logic tx_start;
    logic setup_done;
    logic tx_end;
    logic drive_nxt;
    logic [2:0] dac_load;
    logic det_active;
    logic det_low;
    logic det_accept;
    logic ovr_set;
    logic [INT_W-1:0] sts_set;
    logic [INT_W-1:0] sts_clr;
    logic [INT_W-1:0] sts_nxt;

    // pin synchronisers: a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_r[gi] <= SYNC_RST[gi];
                    sync2_r[gi] <= SYNC_RST[gi];
                    sync3_r[gi] <= SYNC_RST[gi];
                    pin_r[gi] <= SYNC_RST[gi];
                end else begin
                    sync1_r[gi] <= gi < GP_N ? general_purpose_pin[gi % GP_N]
                                             : (gi == GP_N ? cc1_in : cc2_in);
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        pin_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // write path: both channels held, then one write and one response
    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign lane0 = wstrb_r[0];
    assign lane1 = wstrb_r[1];
    assign wr_ctl = wr_fire && awaddr_r == ADDR_CTL;
    assign wr_hit = awaddr_r == ADDR_CTL || awaddr_r == ADDR_DEB
        || awaddr_r == ADDR_TXLEN || awaddr_r == ADDR_PINSEL
        || awaddr_r == ADDR_INT_STS || awaddr_r == ADDR_INT_MASK;

    // address and data may be taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= 16'h0000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awaddr_r <= s_axi_awaddr;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                wready_r <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    assign ctl_word = {swap_request_r, swap_detect_enable_r, pin_trigger_enable_r,
        pin_trigger_level_r, dac_setup_delay_r, mac_override_r, 2'h0,
        cc_pin_select_r, 4'h0};
    assign rd_hit = s_axi_araddr == ADDR_CTL || s_axi_araddr == ADDR_DEB
        || s_axi_araddr == ADDR_TXLEN || s_axi_araddr == ADDR_PINSEL
        || s_axi_araddr == ADDR_INT_STS || s_axi_araddr == ADDR_INT_MASK;
    assign rd_word =
        s_axi_araddr == ADDR_CTL ? {16'h0000, ctl_word} :
        s_axi_araddr == ADDR_DEB ? {24'h000000, swap_cc_debounce_r} :
        s_axi_araddr == ADDR_TXLEN ? {24'h000000, swap_transmit_length_r} :
        s_axi_araddr == ADDR_PINSEL ? {24'h000000, trigger_pin_select_r, 4'h0} :
        s_axi_araddr == ADDR_INT_STS ? {30'h0000_0000, int_sts_r} :
        s_axi_araddr == ADDR_INT_MASK ? {30'h0000_0000, int_mask_r} :
        32'h0000_0000;

    // read path: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // plain configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_detect_enable_r <= 1'b0;
            pin_trigger_enable_r <= 1'b0;
            pin_trigger_level_r <= PIN_LVL_RST;
            dac_setup_delay_r <= DAC_RST;
            cc_pin_select_r <= SEL_RST;
            swap_cc_debounce_r <= BYTE_RST;
            swap_transmit_length_r <= BYTE_RST;
            trigger_pin_select_r <= PINSEL_RST;
            int_mask_r <= '0;
        end else begin
            if (wr_ctl && lane1) begin
                swap_detect_enable_r <= wdata_r[CTL_DET];
                pin_trigger_enable_r <= wdata_r[CTL_PIN_EN];
                pin_trigger_level_r <= wdata_r[CTL_PIN_LVL];
                dac_setup_delay_r <= wdata_r[CTL_DAC_HI:CTL_DAC_LO];
            end
            if (wr_ctl && lane0) begin
                cc_pin_select_r <= wdata_r[CTL_SEL_HI:CTL_SEL_LO];
            end
            if (wr_fire && lane0 && awaddr_r == ADDR_DEB) begin
                swap_cc_debounce_r <= wdata_r[7:0];
            end
            if (wr_fire && lane0 && awaddr_r == ADDR_TXLEN) begin
                swap_transmit_length_r <= wdata_r[7:0];
            end
            if (wr_fire && lane0 && awaddr_r == ADDR_PINSEL) begin
                trigger_pin_select_r <= wdata_r[PINSEL_HI:PINSEL_LO];
            end
            if (wr_fire && lane0 && awaddr_r == ADDR_INT_MASK) begin
                int_mask_r <= wdata_r[INT_W-1:0];
            end
        end
    end

    assign sel_cc1 = cc_pin_select_r[1] || !cc_pin_select_r[0];
    assign sel_cc2 = cc_pin_select_r[1] || cc_pin_select_r[0];

    // pin level match; fire on the edge into assertion
    assign pin_match = pin_r[trigger_pin_select_r] == pin_trigger_level_r;
    assign pin_fire = pin_trigger_enable_r && pin_match && !pin_match_d_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_match_d_r <= 1'b0;
        end else begin
            pin_match_d_r <= pin_trigger_enable_r && pin_match;
        end
    end

    // codes above six clamp to the 500 ns step
    assign dac_load = dac_setup_delay_r > DAC_MAX_CODE ? DAC_MAX_CODE : dac_setup_delay_r;
    // request or pin starts the sequence
    assign tx_start = tx_state_r == TX_IDLE && (swap_request_r || pin_fire);
    assign setup_done = tx_state_r == TX_SETUP && dac_cnt_r == 3'h0;
    // length in whole microseconds, a zero length still ends cleanly
    assign tx_end = tx_state_r == TX_DRIVE && us_cnt_r >= swap_transmit_length_r;
    assign tick.us_restart = setup_done;

    // transmit sequencer next state
    always_comb begin
        tx_state_nxt = tx_state_r;
        unique case (tx_state_r)
            TX_IDLE: begin
                if (tx_start) begin
                    tx_state_nxt = TX_SETUP;
                end
            end
            TX_SETUP: begin
                if (setup_done) begin
                    tx_state_nxt = TX_DRIVE;
                end
            end
            TX_DRIVE: begin
                if (tx_end) begin
                    tx_state_nxt = TX_IDLE;
                end
            end
            default: begin
                tx_state_nxt = TX_IDLE;
            end
        endcase
    end

    // sequencer counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_r <= TX_IDLE;
            dac_cnt_r <= 3'h0;
            us_cnt_r <= 8'h00;
        end else begin
            tx_state_r <= tx_state_nxt;
            if (tx_start) begin
                dac_cnt_r <= dac_load;
            // one step per 12 MHz enable
            end else if (tx_state_r == TX_SETUP && tick.tick_dac && dac_cnt_r != 3'h0) begin
                dac_cnt_r <= dac_cnt_r - 3'h1;
            end
            if (setup_done) begin
                us_cnt_r <= 8'h00;
            end else if (tx_state_r == TX_DRIVE && tick.tick_us) begin
                us_cnt_r <= us_cnt_r + 8'h01;
            end
        end
    end

    // pull the chosen lines low for exactly the drive state
    assign drive_nxt = tx_state_nxt == TX_DRIVE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cc1_oe_n <= 1'b1;
            cc2_oe_n <= 1'b1;
            cc_low_r <= 1'b0;
        end else begin
            cc1_oe_n <= !(drive_nxt && sel_cc1);
            cc2_oe_n <= !(drive_nxt && sel_cc2);
            cc_low_r <= 1'b0;
        end
    end

    // watch only when enabled, and never our own drive
    assign det_active = swap_detect_enable_r && tx_state_r == TX_IDLE;
    assign det_low = (sel_cc1 && !pin_r[GP_N]) || (sel_cc2 && !pin_r[GP_N + 1]);
    // low must persist for the programmed number of sample units
    assign det_accept = det_active && det_low && tick.tick_deb && !det_seen_r
        && det_cnt_r >= swap_cc_debounce_r;

    // debounce counter, rearmed when the line goes back high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            det_cnt_r <= 8'h00;
            det_seen_r <= 1'b0;
        end else if (!det_active || !det_low) begin
            det_cnt_r <= 8'h00;
            det_seen_r <= 1'b0;
        end else if (tick.tick_deb) begin
            if (det_cnt_r != 8'hFF) begin
                det_cnt_r <= det_cnt_r + 8'h01;
            end
            det_seen_r <= det_seen_r || det_accept;
        end
    end

    // sequencer sets override; accepted detection sets it too
    assign ovr_set = setup_done || det_accept;

    // request and override; a hardware set wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_request_r <= 1'b0;
            mac_override_r <= 1'b0;
        end else begin
            // self-clear once the drive has been released
            swap_request_r <= (swap_request_r && !tx_end)
                || (wr_ctl && lane1 && wdata_r[CTL_REQ]);
            if (ovr_set) begin
                mac_override_r <= 1'b1;
            end else if (wr_ctl && lane1) begin
                mac_override_r <= wdata_r[CTL_OVR];
            end
        end
    end

    // isolate the MAC from the pins in use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mac1_r <= 1'b0;
            mac2_r <= 1'b0;
        end else begin
            mac1_r <= mac_override_r && sel_cc1;
            mac2_r <= mac_override_r && sel_cc2;
        end
    end

    // sticky events, write one to clear, set wins
    assign sts_set = {det_accept, tx_end};
    assign sts_clr = wr_fire && lane0 && awaddr_r == ADDR_INT_STS ? wdata_r[INT_W-1:0] : '0;
    assign sts_nxt = sts_set | (int_sts_r & ~sts_clr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_sts_r <= '0;
            irq_r <= 1'b0;
        end else begin
            int_sts_r <= sts_nxt;
            irq_r <= |(sts_nxt & int_mask_r);
        end
    end

    // outputs
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign cc1_out = cc_low_r;
    assign cc2_out = cc_low_r;
    assign mac_cc1_disconnect = mac1_r;
    assign mac_cc2_disconnect = mac2_r;
    assign irq = irq_r;

endmodule : frsc_core

// file: testbench/frsc_core_properties.sv
// Purpose: port timing checks of the swap control block
// Assumes: one aclk domain, sync active low reset
// Notes: bound to every frsc_core instance
`timescale 1ns/1ns
module frsc_core_properties
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cc pins and isolation
    input wire logic cc1_out,
    input wire logic cc2_out,
    input wire logic cc1_oe_n,
    input wire logic cc2_oe_n,
    input wire logic mac_cc1_disconnect,
    input wire logic mac_cc2_disconnect
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // bus answers stand until taken
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during answer");
    // open drain: a pin is only ever pulled low
    cc_low_only_a:
        assert property (!cc1_out && !cc2_out) else $error("cc driven high");
    drive_min_a:
        assert property ($fell(cc1_oe_n) |-> !cc1_oe_n [*8]) else $error("drive cut short");
    // isolation lags drive start by one edge
    mac1_drive_a:
        assert property ($fell(cc1_oe_n) |=> mac_cc1_disconnect) else $error("cc1 mac live");
    mac2_drive_a:
        assert property ($fell(cc2_oe_n) |-> ##1 mac_cc2_disconnect [*2])
        else $error("cc2 mac live");
endmodule : frsc_core_properties
bind frsc_core frsc_core_properties frsc_core_properties_i (.*);

// file: testbench/frsc_cc_partner.sv
// Purpose: port partner on the two cc wires
// Assumes: wires pulled up when nobody pulls low
// Notes: measures how long the block holds a wire low
`timescale 1ns/1ns
module frsc_cc_partner
(
    // clock
    input wire logic aclk,
    // wires
    input wire logic [1:0] dev_oe_n,
    output logic [1:0] line,
    output int low_len
);
    logic [1:0] pull_r = 2'h0;
    int run_r = 0;
    assign line = dev_oe_n & ~pull_r;
    // last low stretch of the block
    always @(posedge aclk) begin
        run_r <= (&dev_oe_n) ? 0 : run_r + 1;
        if (&dev_oe_n && run_r != 0) low_len <= run_r;
    end
    // pull low for n cycles, then release
    task automatic pull(input logic [1:0] w, input int n);
        pull_r <= w;
        repeat (n) @(posedge aclk);
        pull_r <= 2'h0;
    endtask : pull
endmodule : frsc_cc_partner

// file: testbench/tb_top.sv
// Purpose: register level bench of the swap control block
// Assumes: partner model on both cc wires
// Notes: 2 us transmit length keeps the run short
`timescale 1ns/1ns
module tb_top;
    import frsc_pkg::*;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, general_purpose_pin = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cc1_in, cc2_in;
    logic cc1_out, cc2_out, cc1_oe_n, cc2_oe_n, mac_cc1_disconnect, mac_cc2_disconnect;
    logic [2:0] dac;
    int n_fail = 0, comparisons = 0, cyc = 0, len, t, d[4];
    wire [1:0] oe = {cc2_oe_n, cc1_oe_n};
    wire [1:0] mac = {mac_cc2_disconnect, mac_cc1_disconnect};
    always #25 aclk = ~aclk;
    frsc_core frsc_core_i (.*);
    frsc_cc_partner frsc_cc_partner_i (.aclk(aclk), .dev_oe_n(oe), .line({cc2_in, cc1_in}),
        .low_len(len));
    task automatic stop_test;
        $display("n_fail %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bus master: hold each channel until its own ready
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
        end while (!s_axi_bready);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic [1:0] er = 2'h0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
        end while (!s_axi_rready);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, x);
        chk(s_axi_rresp, er);
    endtask : rd
    // let registered outputs settle
    task automatic nap;
        repeat (3) @(posedge aclk);
    endtask : nap
    // wait out one drive; t is its start delay
    task automatic drv;
        for (t = 0; &oe && t < 300; t++) @(posedge aclk);
        while (!(&oe)) @(posedge aclk);
    endtask : drv
    // hang guard, well past the run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(ADDR_CTL, 32'h1000);
        rd(16'h0000, 32'h0, RESP_SLVERR);
        wr(16'h0000, 32'h0, RESP_SLVERR);
        wr(ADDR_INT_MASK, 32'h3);
        wr(ADDR_TXLEN, 32'h2);
        for (int i = 0; i < 4; i++) begin
            dac = i[1] ? {2'h3, i[0]} : 3'h0;
            wr(ADDR_CTL, {16'h0, 4'h9, dac, 3'h0, i[1:0], 4'h0});
            for (t = 0; &oe && t < 300; t++) @(posedge aclk);
            d[i] = t;
            chk(oe, i[1] ? 2'h0 : (i[0] ? 2'h1 : 2'h2));
            drv();
            nap();
            chk(len, 2 * CYC_PER_US + 2);
            chk(mac, i[1] ? 2'h3 : (i[0] ? 2'h2 : 2'h1));
            rd(ADDR_CTL, {16'h0, 4'h1, dac, 1'h1, 2'h0, i[1:0], 4'h0});
            chk(irq, 1'h1);
            wr(ADDR_INT_STS, 32'h1);
            wr(ADDR_CTL, 32'h1000);
            nap();
            chk({irq, mac}, 3'h0);
        end
        chk({d[2] - d[0] inside {[9:10]}, d[3] - d[0] inside {[9:10]}}, 32'h3);
        general_purpose_pin <= 16'h0008;
        wr(ADDR_PINSEL, 32'h30);
        wr(ADDR_CTL, 32'h2000);
        nap();
        chk(oe, 2'h3);
        general_purpose_pin <= 16'h0000;
        drv();
        chk(t < 300, 32'h1);
        wr(ADDR_CTL, 32'h1000);
        wr(ADDR_INT_STS, 32'h1);
        wr(ADDR_DEB, 32'h2);
        wr(ADDR_CTL, 32'h1010);
        frsc_cc_partner_i.pull(2'h2, 800);
        nap();
        chk(mac, 2'h0);
        wr(ADDR_CTL, 32'h5010);
        frsc_cc_partner_i.pull(2'h2, 60);
        nap();
        chk(mac, 2'h0);
        frsc_cc_partner_i.pull(2'h2, 800);
        nap();
        chk({irq, mac}, 3'h6);
        rd(ADDR_INT_STS, 32'h2);
        stop_test();
    end
endmodule : tb_top
